// ===== lcd_frame_duty_control.v
// LCD frame rate, duty decode, regulator bits and frame interrupt
// What this block does
// R1: Frame divisors 256, 512, 680, 1024; reset 512
// R2: One-third duty uses 252, 504, 681, 1008
// R3: High-speed source: predivided then frame divided
// R4: Output enable drives frame onto pin
// R5: Enable clear holds frame pin low
// R6: Duty codes static..eighth, reset eighth
// R7: Large package commons and segments per duty
// R8: Small package segment counts per duty
// R9: Heavy-load protect bit four, resets off
// R10: Reference select bit zero, resets first
// R11: Frame interrupt enable bit, resets off
// R12: Flag set on frame rise, write-one clears
// R13: Interrupt request when enabled and flagged
// R14: Predivider 1/32 to 1/512 by code
// R15: Reloading counter produces frame signal
//
// The address-and-strobe port was decided locally.
`default_nettype none
`include "lcd_frame_regs.vh"
module lcd_frame_duty_control #(
   parameter LARGE_PACKAGE = 1
) (
   input  wire        ref_clk,
   input  wire        reset_n,
   input  wire        clk_en,
   input  wire        low_speed_tick,
   input  wire        high_speed_tick,
   input  wire [15:0] addr,
   input  wire [7:0]  wdata,
   input  wire        wr_stb,
   input  wire        rd_stb,
   output reg  [7:0]  rdata,
   output wire        frame_signal_pin,
   output wire [7:0]  common_output_en,
   output wire [55:0] segment_output_en,
   output wire        heavy_load_protect,
   output wire        regulator_reference_select,
   output wire        frame_irq,
   output wire        event_irq
);
   reg  [1:0]  frame_sel_q;
   reg         frame_out_q;
   reg  [2:0]  duty_q;
   reg         heavy_q;
   reg         ref_sel_q;
   reg         frame_ie_q;
   reg         frame_if_q;
   reg         src_hs_q;
   reg  [2:0]  prediv_q;
   reg  [1:0]  ev_status_q;
   reg  [1:0]  ev_enable_q;
   reg  [10:0] divisor;
   reg  [7:0]  rdata_d;
   wire        hs_div_tick;
   wire        src_tick;
   wire        frame_q;
   wire        frame_rise;
   wire [1:0]  ev_set;
   wire        wr_clock = wr_stb && (addr == `ADDR_CLOCK_CONTROL);
   wire        wr_flag  = wr_stb && (addr == `ADDR_INTERRUPT_FLAG);
   wire        wr_evclr = wr_stb && (addr == `ADDR_EVENT_CLEAR);

   // Number of active commons for a duty code; reserved codes drive none
   function [3:0] commons_for;
      input [2:0] d;
      begin
         case (d)
            `DUTY_STATIC:  commons_for = 4'h1;
            `DUTY_HALF:    commons_for = 4'h2;
            `DUTY_THIRD:   commons_for = 4'h3;
            `DUTY_QUARTER: commons_for = 4'h4;
            `DUTY_EIGHTH:  commons_for = 4'h8;
            default:       commons_for = 4'h0;
         endcase
      end
   endfunction

   // Number of active segments for duty and package
   function [6:0] segments_for;
      input [2:0] d;
      begin
         if (d > `DUTY_EIGHTH)
            segments_for = 7'h00;
         else if (d == `DUTY_EIGHTH)
            segments_for = LARGE_PACKAGE ? 7'h34 : 7'h24; // R7 R8
         else
            segments_for = LARGE_PACKAGE ? 7'h38 : 7'h28; // R7 R8
      end
   endfunction

   // Divisor from frame select, with the one-third duty set of values
   always @* begin
      if (duty_q == `DUTY_THIRD) begin
         case (frame_sel_q) // R2
            2'h0:    divisor = `DIV_252;
            2'h1:    divisor = `DIV_504;
            2'h2:    divisor = `DIV_681;
            default: divisor = `DIV_1008;
         endcase
      end else begin
         case (frame_sel_q) // R1
            2'h0:    divisor = `DIV_256;
            2'h1:    divisor = `DIV_512;
            2'h2:    divisor = `DIV_680;
            default: divisor = `DIV_1024;
         endcase
      end
   end

   // Source tick: predivided high-speed clock or low-speed oscillator
   assign src_tick = src_hs_q ? hs_div_tick : low_speed_tick; // R3

   lcd_prescaler u_prescaler (
      .ref_clk    (ref_clk),
      .reset_n    (reset_n),
      .clk_en     (clk_en),
      .hs_tick    (high_speed_tick),
      .prediv_sel (prediv_q),
      .tick_out   (hs_div_tick)
   );

   lcd_frame_divider u_divider (
      .ref_clk    (ref_clk),
      .reset_n    (reset_n),
      .clk_en     (clk_en),
      .src_tick   (src_tick),
      .divisor    (divisor),
      .frame_q    (frame_q),
      .frame_rise (frame_rise)
   );

   // Pin is low whenever output is disabled
   assign frame_signal_pin = frame_out_q & frame_q; // R4 R5

   // Common and segment enables, one per output
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_com
         assign common_output_en[gi] = (gi < commons_for(duty_q)); // R6 R7
      end
      for (gi = 0; gi < 56; gi = gi + 1) begin : g_seg
         assign segment_output_en[gi] = (gi < segments_for(duty_q)); // R7 R8
      end
   endgenerate

   assign heavy_load_protect         = heavy_q; // R9
   assign regulator_reference_select = ref_sel_q; // R10
   assign frame_irq                  = frame_ie_q & frame_if_q; // R13

   // Events: bit0 frame rise, bit1 reserved duty code written
   assign ev_set    = {wr_clock && (wdata[`DUTY_HI:`DUTY_LO] > `DUTY_EIGHTH), frame_rise};
   assign event_irq = |(ev_status_q & ev_enable_q);

   // Register writes; hardware set wins over software clear
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         frame_sel_q <= `FRAME_SEL_RESET;
         frame_out_q <= 1'b0;
         duty_q      <= `DUTY_RESET;
         heavy_q     <= 1'b0;
         ref_sel_q   <= 1'b0;
         frame_ie_q  <= 1'b0;
         frame_if_q  <= 1'b0;
         src_hs_q    <= 1'b0;
         prediv_q    <= `PREDIV_RESET;
         ev_status_q <= 2'h0;
         ev_enable_q <= 2'h0;
      end else if (clk_en) begin
         if (wr_clock) begin
            frame_sel_q <= wdata[`FRAME_SEL_HI:`FRAME_SEL_LO]; // R1
            frame_out_q <= wdata[`FRAME_OUT_BIT]; // R4
            duty_q      <= wdata[`DUTY_HI:`DUTY_LO]; // R6
         end
         if (wr_stb && addr == `ADDR_REGULATOR_CONTROL) begin
            heavy_q   <= wdata[`HEAVY_LOAD_BIT]; // R9
            ref_sel_q <= wdata[`REF_SEL_BIT]; // R10
         end
         if (wr_stb && addr == `ADDR_INTERRUPT_MASK)
            frame_ie_q <= wdata[`FRAME_IE_BIT]; // R11
         if (wr_stb && addr == `ADDR_SOURCE_CONTROL) begin
            src_hs_q <= wdata[3];
            prediv_q <= wdata[2:0]; // R14
         end
         if (wr_stb && addr == `ADDR_EVENT_ENABLE)
            ev_enable_q <= wdata[1:0];
         // Set has priority so a rise during the clear is kept
         if (frame_rise)
            frame_if_q <= 1'b1; // R12
         else if (wr_flag && wdata[0])
            frame_if_q <= 1'b0; // R12
         ev_status_q <= ev_set | (ev_status_q & ~(wr_evclr ? wdata[1:0] : 2'h0));
      end
   end

   // Read mux; unmapped addresses read zero
   always @* begin
      rdata_d = 8'h00;
      case (addr)
         `ADDR_CLOCK_CONTROL:     rdata_d = {frame_sel_q, frame_out_q, 2'h0, duty_q};
         `ADDR_REGULATOR_CONTROL: rdata_d = {3'h0, heavy_q, 3'h0, ref_sel_q};
         `ADDR_INTERRUPT_MASK:    rdata_d = {7'h00, frame_ie_q};
         `ADDR_INTERRUPT_FLAG:    rdata_d = {7'h00, frame_if_q};
         `ADDR_SOURCE_CONTROL:    rdata_d = {4'h0, src_hs_q, prediv_q};
         `ADDR_EVENT_STATUS:      rdata_d = {6'h00, ev_status_q};
         `ADDR_EVENT_ENABLE:      rdata_d = {6'h00, ev_enable_q};
         default:                 rdata_d = 8'h00;
      endcase
   end

   // Read data stands after the strobe until the next enabled cycle without it
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n)
         rdata <= 8'h00;
      else if (clk_en)
         rdata <= rd_stb ? rdata_d : 8'h00;
   end
endmodule
`default_nettype wire

// ===== lcd_frame_regs.vh
// Register offsets, field positions, reset values and divisors for the LCD frame block
`ifndef LCD_FRAME_REGS_VH
`define LCD_FRAME_REGS_VH
`define ADDR_CLOCK_CONTROL     16'h50A2
`define ADDR_REGULATOR_CONTROL 16'h50A3
`define ADDR_INTERRUPT_MASK    16'h50A5
`define ADDR_INTERRUPT_FLAG    16'h50A6
`define ADDR_SOURCE_CONTROL    16'h50A8
`define ADDR_EVENT_STATUS      16'h50AA
`define ADDR_EVENT_CLEAR       16'h50AC
`define ADDR_EVENT_ENABLE      16'h50AE
`define FRAME_SEL_HI           7
`define FRAME_SEL_LO           6
`define FRAME_OUT_BIT          5
`define DUTY_HI                2
`define DUTY_LO                0
`define HEAVY_LOAD_BIT         4
`define REF_SEL_BIT            0
`define FRAME_IE_BIT           0
`define FRAME_SEL_RESET        2'h1
`define DUTY_RESET             3'h4
`define PREDIV_RESET           3'h0
`define DUTY_STATIC            3'h0
`define DUTY_HALF              3'h1
`define DUTY_THIRD             3'h2
`define DUTY_QUARTER           3'h3
`define DUTY_EIGHTH            3'h4
`define DIV_256                11'h100
`define DIV_512                11'h200
`define DIV_680                11'h2A8
`define DIV_1024               11'h400
`define DIV_252                11'h0FC
`define DIV_504                11'h1F8
`define DIV_681                11'h2A9
`define DIV_1008               11'h3F0
`endif

// ===== lcd_prescaler.v
// High-speed clock predivider producing source-clock enable ticks
`default_nettype none
module lcd_prescaler (
   input  wire       ref_clk,
   input  wire       reset_n,
   input  wire       clk_en,
   input  wire       hs_tick,
   input  wire [2:0] prediv_sel,
   output reg        tick_out
);
   reg  [8:0] count_q;
   reg  [8:0] limit;

   // Divide by 32..512; reserved codes fall back to 1/512
   always @* begin
      case (prediv_sel)
         3'h0:    limit = 9'h01F;
         3'h1:    limit = 9'h03F;
         3'h2:    limit = 9'h07F;
         3'h3:    limit = 9'h0FF;
         default: limit = 9'h1FF;
      endcase
   end

   // Counts high-speed ticks, one output tick per period
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         count_q  <= 9'h000;
         tick_out <= 1'b0;
      end else if (clk_en) begin
         tick_out <= 1'b0;
         if (hs_tick) begin
            if (count_q >= limit) begin // R14
               count_q  <= 9'h000;
               tick_out <= 1'b1;
            end else begin
               count_q <= count_q + 9'h001;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== lcd_frame_divider.v
// Frame divider: reloading counter that toggles the frame signal
`default_nettype none
module lcd_frame_divider (
   input  wire        ref_clk,
   input  wire        reset_n,
   input  wire        clk_en,
   input  wire        src_tick,
   input  wire [10:0] divisor,
   output reg         frame_q,
   output reg         frame_rise
);
   reg  [10:0] count_q;
   wire [10:0] half = {1'b0, divisor[10:1]};

   // High for first half of the period, low for the rest; one rise per period
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         count_q    <= 11'h000;
         frame_q    <= 1'b0;
         frame_rise <= 1'b0;
      end else if (clk_en) begin
         frame_rise <= 1'b0;
         if (src_tick) begin
            if (count_q >= divisor - 11'h001) begin // R15
               count_q    <= 11'h000;
               frame_q    <= 1'b1;
               frame_rise <= 1'b1;
            end else begin
               count_q <= count_q + 11'h001;
               if (count_q + 11'h001 == half) begin
                  frame_q <= 1'b0;
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== lcd_frame_expect.svh
// Expected divisor, common and segment patterns for the frame block
// Frame divisor; one-third duty swaps in its own set
function automatic logic [10:0] div_f(input logic [7:0] c);
   logic t;
   t = c[2:0] == 3'h2;
   case (c[7:6])
      2'h0: div_f = t ? 11'h0FC : 11'h100;
      2'h1: div_f = t ? 11'h1F8 : 11'h200;
      2'h2: div_f = t ? 11'h2A9 : 11'h2A8;
      default: div_f = t ? 11'h3F0 : 11'h400;
   endcase
endfunction
// Active lines of the large package; reserved duties drive none
function automatic logic [7:0] com_f(input logic [2:0] d);
   com_f = d == 3'h4 ? 8'hFF : d > 3'h4 ? 8'h00 : 8'h0F >> (3'h3 - d);
endfunction
function automatic logic [55:0] seg_f(input logic [2:0] d);
   seg_f = d > 3'h4 ? 56'h0 : d == 3'h4 ? {4'h0, {52{1'b1}}} : {56{1'b1}};
endfunction

// ===== lcd_frame_duty_control_assertions.sv
// Port checks for the LCD frame block
`default_nettype none
module lcd_frame_duty_control_assertions (
   input wire logic        ref_clk,
   input wire logic        reset_n,
   input wire logic        clk_en,
   input wire logic        low_speed_tick,
   input wire logic [15:0] addr,
   input wire logic [7:0]  wdata,
   input wire logic        wr_stb,
   input wire logic        frame_signal_pin,
   input wire logic [7:0]  common_output_en,
   input wire logic        heavy_load_protect,
   input wire logic        regulator_reference_select,
   input wire logic        frame_irq
);
   `include "lcd_frame_expect.svh"
   logic [7:0]  cc_q;
   logic [11:0] n_q;
   logic        ie_q, src_q, p1_q, ok_q, wr1_q;
   wire         wr_cc = wr_stb && clk_en && addr == 16'h50A2;
   wire         wr_src = wr_stb && clk_en && addr == 16'h50A8;
   wire         clr = wr_stb && clk_en && addr == 16'h50A6;
   wire         rise = frame_signal_pin && !p1_q;
   // Shadow registers; slow ticks counted since the last visible rise
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cc_q <= 8'h44;
         {ie_q, src_q, p1_q, ok_q, wr1_q} <= 5'h00;
         n_q <= 12'h000;
      end else begin
         p1_q <= frame_signal_pin;
         n_q <= (rise ? 12'h000 : n_q) + {11'h0, low_speed_tick};
         if (wr_cc) cc_q <= wdata;
         if (wr_stb && clk_en && addr == 16'h50A5) ie_q <= wdata[0];
         if (wr_src) src_q <= wdata[3];
         // Enabling the pin mid-frame shows a rise that is no frame edge
         wr1_q <= wr_cc || wr_src;
         // A setting change or a freeze spoils the running period, so skip it
         if (wr_cc || wr_src || !clk_en) ok_q <= 1'b0;
         else if (rise && !wr1_q) ok_q <= !src_q;
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   sequence rise_s;
      ie_q && !wr1_q && $rose(frame_signal_pin);
   endsequence
   pin_low_a: assert property (!cc_q[5] |-> !frame_signal_pin)
      else $error("frame pin high while off");
   frame_period_a: assert property (rise && ok_q |-> n_q == {1'b0, div_f(cc_q)})
      else $error("frame period wrong");
   com_decode_a: assert property (common_output_en == com_f(cc_q[2:0]))
      else $error("common lines wrong");
   reg_bits_a: assert property (wr_stb && clk_en && addr == 16'h50A3 |=>
      {3'h0, heavy_load_protect, 3'h0, regulator_reference_select} == ($past(wdata) & 8'h11))
      else $error("regulator bits wrong");
   irq_gate_a: assert property (frame_irq |-> ie_q)
      else $error("irq while masked");
   flag_set_a: assert property (rise_s |-> ##[0:1] frame_irq)
      else $error("no irq on frame rise");
   flag_clear_a: assert property (clr && wdata[0] && cc_q[5] && !rise |=> !frame_irq || rise)
      else $error("flag not cleared");
   flag_keep_a: assert property (clr && !wdata[0] && frame_irq |=> frame_irq)
      else $error("flag lost on zero write");
endmodule
`default_nettype wire

// ===== lcd_panel_model.sv
// Segment panel stand-in: counts the lines being driven
`default_nettype none
module lcd_panel_model (
   input  wire logic [7:0]  common_output_en,
   input  wire logic [55:0] segment_output_en,
   output var  logic [3:0]  com_lines,
   output var  logic [5:0]  seg_lines
);
   // One row per driven common, one column per driven segment
   always_comb begin
      com_lines = 4'($countones(common_output_en));
      seg_lines = 6'($countones(segment_output_en));
   end
endmodule
`default_nettype wire

// ===== lcd_frame_duty_control_test.sv
// Self-checking bench for the LCD frame and duty control block
`default_nettype none
module lcd_frame_duty_control_test;
   timeunit 1ns;
   timeprecision 1ns;
   `include "lcd_frame_expect.svh"
   logic        ref_clk, reset_n, wr_stb, rd_stb, src;
   logic        clk_en = 1'b1;
   logic        low_speed_tick = 1'b0;
   logic        high_speed_tick = 1'b0;
   logic        frame_signal_pin, heavy_load_protect, regulator_reference_select;
   logic        frame_irq, event_irq;
   logic [15:0] addr;
   logic [7:0]  wdata, rdata, common_output_en;
   logic [55:0] segment_output_en;
   logic [3:0]  com_lines;
   logic [5:0]  seg_lines;
   logic [31:0] seed = 32'h1AD3E553;
   logic [31:0] r, h;
   logic [1:0]  ph = 2'h0;
   logic [7:0]  cfg [3] = '{8'hE2, 8'hA4, 8'h22};
   int          num_errors, checks_done;
   lcd_frame_duty_control dut_u (
      .ref_clk                    (ref_clk),
      .reset_n                    (reset_n),
      .clk_en                     (clk_en),
      .low_speed_tick             (low_speed_tick),
      .high_speed_tick            (high_speed_tick),
      .addr                       (addr),
      .wdata                      (wdata),
      .wr_stb                     (wr_stb),
      .rd_stb                     (rd_stb),
      .rdata                      (rdata),
      .frame_signal_pin           (frame_signal_pin),
      .common_output_en           (common_output_en),
      .segment_output_en          (segment_output_en),
      .heavy_load_protect         (heavy_load_protect),
      .regulator_reference_select (regulator_reference_select),
      .frame_irq                  (frame_irq),
      .event_irq                  (event_irq)
   );
   lcd_panel_model panel_u (
      .common_output_en  (common_output_en),
      .segment_output_en (segment_output_en),
      .com_lines         (com_lines),
      .seg_lines         (seg_lines)
   );
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [55:0] g, e);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge ref_clk);
      wr_stb <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge ref_clk);
      rd_stb <= 1'b0;
      #1 chk(rdata, e);
   endtask
   // Source ticks of the selected clock across one full frame
   task automatic meas(input logic [31:0] e);
      logic [31:0] n;
      logic p, go, hp;
      n = 0;
      p = 1'b1;
      go = 1'b0;
      hp = 1'b0;
      for (int i = 0; i < 40000; i++) begin
         @(posedge ref_clk);
         #1;
         if (frame_signal_pin && !p) begin
            if (go) begin
               chk(n, e);
               return;
            end
            go = 1'b1;
            n = 0;
         end
         // Predivider output lags its input tick by one cycle
         n += src ? hp : low_speed_tick;
         hp = high_speed_tick;
         p = frame_signal_pin;
      end
      chk(32'h0, e);
      report_and_stop();
   endtask
   task automatic report_and_stop();
      if (num_errors == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   // Slow ticks every third cycle; fast ones random, most cycles
   always @(posedge ref_clk) begin
      h = xs();
      ph <= ph == 2'h2 ? 2'h0 : ph + 2'h1;
      low_speed_tick <= ph == 2'h2;
      high_speed_tick <= h[1:0] != 2'h0;
   end
   initial begin
      {reset_n, wr_stb, rd_stb, src} = 4'h0;
      {addr, wdata} = 24'h0;
      num_errors = 0;
      checks_done = 0;
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      rd(16'h50A2, 8'h44);
      rd(16'h50A3, 8'h00);
      rd(16'h50A5, 8'h00);
      rd(16'h50A4, 8'h00);
      // Every duty code with a random frame select, output off
      for (int d = 0; d < 8; d++) begin
         r = xs();
         wr(16'h50A2, {r[1:0], 3'h0, 3'(d)});
         #1 chk(segment_output_en, seg_f(3'(d)));
         chk(com_lines, 56'($countones(com_f(3'(d)))));
         chk(seg_lines, 56'($countones(seg_f(3'(d)))));
         rd(16'h50A2, {r[1:0], 3'h0, 3'(d)});
      end
      foreach (cfg[k]) begin
         wr(16'h50A2, cfg[k]);
         meas({21'h0, div_f(cfg[k])});
      end
      wr(16'h50A5, 8'h01);
      wr(16'h50AE, 8'h01);
      rd(16'h50A5, 8'h01);
      // Clear stale flags so the next rise must set them again
      wr(16'h50A6, 8'h01);
      wr(16'h50AC, 8'h01);
      #1 chk({frame_irq, event_irq}, 2'h0);
      meas(32'h0FC);
      @(posedge ref_clk);
      #1 chk({frame_irq, event_irq}, 2'h3);
      rd(16'h50AA, 8'h03);
      wr(16'h50A6, 8'h00);
      #1 chk(frame_irq, 1'b1);
      wr(16'h50A6, 8'h01);
      wr(16'h50AC, 8'h03);
      #1 chk({frame_irq, event_irq}, 2'h0);
      wr(16'h50A5, 8'h00);
      meas(32'h0FC);
      rd(16'h50A6, 8'h01);
      chk(frame_irq, 1'b0);
      wr(16'h50A3, 8'hFF);
      #1 chk({heavy_load_protect, regulator_reference_select}, 2'h3);
      rd(16'h50A3, 8'h11);
      // Frozen clock enable must drop this write
      clk_en <= 1'b0;
      wr(16'h50A3, 8'h00);
      clk_en <= 1'b1;
      rd(16'h50A3, 8'h11);
      wr(16'h50A2, 8'h02);
      // Longer than one 252-tick frame at three cycles a tick
      repeat (800) @(posedge ref_clk);
      #1 chk(frame_signal_pin, 1'b0);
      wr(16'h50A8, 8'h08);
      src = 1'b1;
      wr(16'h50A2, 8'h24);
      meas(32'h2000);
      report_and_stop();
   end
endmodule
bind lcd_frame_duty_control lcd_frame_duty_control_assertions chk_u (
   .ref_clk                    (ref_clk),
   .reset_n                    (reset_n),
   .clk_en                     (clk_en),
   .low_speed_tick             (low_speed_tick),
   .addr                       (addr),
   .wdata                      (wdata),
   .wr_stb                     (wr_stb),
   .frame_signal_pin           (frame_signal_pin),
   .common_output_en           (common_output_en),
   .heavy_load_protect         (heavy_load_protect),
   .regulator_reference_select (regulator_reference_select),
   .frame_irq                  (frame_irq)
);
`default_nettype wire
